/* logic/psram_map.svh */
// Register offsets, config fields, reset values and timing counts of the burst memory block
`ifndef PSRAM_MAP_SVH
`define PSRAM_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFF_CONFIG      8'h00
`define OFF_STATUS      8'h04
`define OFF_CONTROL     8'h08

// ****************************************************************
// Burst config word fields and reset value
// ****************************************************************
`define CFG_RESET       16'h9D1F
`define CFG_MODE_BIT    15
`define CFG_FIXED_BIT   14
`define CFG_LC_HI       13
`define CFG_LC_LO       11
`define CFG_WPOL_BIT    10
`define CFG_WTIM_BIT    8
`define CFG_NOWRAP_BIT  3

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ           50
`define INIT_PERIOD_US    150
`define INIT_CYCLES       (`INIT_PERIOD_US * `CLK_MHZ)
`define SLEEP_MIN_US      150
`define SLEEP_MIN_CYCLES  (`SLEEP_MIN_US * `CLK_MHZ)
`define SLEEP_EXIT_US     10
`define SLEEP_EXIT_CYCLES (`SLEEP_EXIT_US * `CLK_MHZ)
`define REFRESH_CYCLES    200
`define ROW_LOG2          7

// ****************************************************************
// Bus responses
// ****************************************************************
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* logic/psram_pkg.sv */
// Types shared by the burst memory block
`default_nettype none
package psram_pkg;

  // One-hot burst engine states
  typedef enum logic [5:0] {
    ST_INIT   = 6'h01,
    ST_IDLE   = 6'h02,
    ST_LAT    = 6'h04,
    ST_DATA   = 6'h08,
    ST_ROWEND = 6'h10,
    ST_SLEEP  = 6'h20
  } state_t;

endpackage : psram_pkg
`default_nettype wire

/* logic/psram_word_fifo.sv */
// Small synchronous FIFO that buffers write words ahead of the array
`timescale 1ns/1ns
`default_nettype none
module psram_word_fifo #(
  parameter int W     = 38,
  parameter int DEPTH = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic      [W-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  store [DEPTH];
  logic [PW-1:0] wrPtrQ;
  logic [PW-1:0] rdPtrQ;
  logic [CW-1:0] countQ;
  logic          pushFire;
  logic          popFire;

  // ****************************************************************
  // Flags
  // ****************************************************************
  assign inReady  = (countQ != CW'(DEPTH));
  assign outValid = (countQ != '0);
  assign outData  = store[rdPtrQ];
  assign pushFire = inValid && inReady;
  assign popFire  = outValid && outReady;

  // Storage has no reset, only the pointers and the count need one
  always_ff @(posedge ref_clk) begin
    if (pushFire) begin
      store[wrPtrQ] <= inData;
    end
  end

  // Pointers wrap at DEPTH so depths other than powers of two work
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else begin
      if (pushFire) begin
        wrPtrQ <= (wrPtrQ == PW'(DEPTH - 1)) ? '0 : wrPtrQ + PW'(1);
      end
      if (popFire) begin
        rdPtrQ <= (rdPtrQ == PW'(DEPTH - 1)) ? '0 : rdPtrQ + PW'(1);
      end
      countQ <= countQ + CW'(pushFire) - CW'(popFire);
    end
  end

endmodule : psram_word_fifo
`default_nettype wire

/* logic/psram_burst_refresh_interface.sv */
// Burst interface, refresh scheduling and power sequencing of a self-refreshing pseudo-static memory
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "psram_map.svh"
module psram_burst_refresh_interface #(
  parameter int AW               = 20,
  parameter int INIT_CYCLES      = `INIT_CYCLES,
  parameter int SLEEP_MIN_CYCLES = `SLEEP_MIN_CYCLES,
  parameter int REFRESH_CYCLES   = `REFRESH_CYCLES,
  parameter int FIFO_DEPTH       = 8
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          memClk,
  input  wire logic          selectN,
  input  wire logic          addr_valid_n,
  input  wire logic          writeN,
  input  wire logic          outEnN,
  input  wire logic          low_byte_sel_n,
  input  wire logic          high_byte_sel_n,
  input  wire logic [AW-1:0] memAddr,
  input  wire logic [15:0]   dqIn,
  output logic [15:0]        dqOut,
  output logic               dqOe,
  output logic               waitOut,
  output logic               waitOe
);
  import psram_pkg::*;

  localparam int PW = AW + 23;
  localparam int FW = AW + 18;
  localparam int IW = $clog2(INIT_CYCLES + 1);
  localparam int SW = $clog2(SLEEP_MIN_CYCLES + 1);
  localparam int XW = $clog2(`SLEEP_EXIT_CYCLES + 1);
  localparam int RW = $clog2(REFRESH_CYCLES + 1);

  // ****************************************************************
  // Pin synchronisers and link clock edge
  // ****************************************************************
  logic [PW-1:0] pinRaw;
  logic [PW-1:0] pinS1Q;
  logic [PW-1:0] pinS2Q;
  logic          clkPrevQ;
  logic          sClk, sSelN, sAdvN, sWeN, sOeN, sLbN, sUbN;
  logic [15:0]   sDq;
  logic [AW-1:0] sAddr;
  logic          clkRise;

  assign pinRaw = {memClk, selectN, addr_valid_n, writeN, outEnN, low_byte_sel_n, high_byte_sel_n, dqIn, memAddr};

  // Data and strobes share one delay so they stay coherent with the clock edge
  always_ff @(posedge ref_clk) begin
    pinS1Q <= pinRaw;
    pinS2Q <= pinS1Q;
  end

  assign {sClk, sSelN, sAdvN, sWeN, sOeN, sLbN, sUbN, sDq, sAddr} = pinS2Q;

  // Edge finder reads only the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clkPrevQ <= 1'b0;
    end else begin
      clkPrevQ <= sClk;
    end
  end
  assign clkRise = sClk && !clkPrevQ;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [15:0]   cfgQ;
  logic          sleepReqQ;
  state_t        stateQ;
  logic [4:0]    latQ;
  logic [AW-1:0] addrQ;
  logic          isWriteQ;
  logic [IW-1:0] initCntQ;
  logic          initDoneQ;
  logic [SW-1:0] sleepCntQ;
  logic [XW-1:0] exitCntQ;
  logic [RW-1:0] refCntQ;
  logic          refreshDueQ;
  logic [2:0]    lc;
  logic          syncMode;
  logic          burstStart;
  logic          collide;
  logic [4:0]    latStart;
  logic          dataEdge;
  logic          wrEdge;
  logic          rdEdge;
  logic          rowEnd;
  logic          waitLvl;
  logic          sleepExit;
  logic          fifoInReady;
  logic          fifoOutValid;
  logic [FW-1:0] fifoOutData;

  assign lc       = cfgQ[`CFG_LC_HI:`CFG_LC_LO];
  assign syncMode = !cfgQ[`CFG_MODE_BIT];

  // ****************************************************************
  // Burst decode
  // ****************************************************************
  // A burst only starts on a link clock edge with select and address-valid low
  assign burstStart = clkRise && !sSelN && !sAdvN && initDoneQ && syncMode
                      && (stateQ != ST_SLEEP) && (stateQ != ST_INIT);
  assign collide    = burstStart && sWeN && !cfgQ[`CFG_FIXED_BIT] && refreshDueQ;
  // Reads wait code+1, or twice the code on a refresh hit so wait never outlasts 2x code
  assign latStart   = sWeN ? (collide ? (5'(lc) + 5'(lc)) : (5'(lc) + 5'h01))
                           : 5'(lc);
  assign dataEdge   = clkRise && (stateQ == ST_DATA) && !sSelN && !burstStart;
  // Write words are taken only while the buffer has room; wait shows otherwise
  assign wrEdge     = dataEdge && isWriteQ && fifoInReady;
  assign rdEdge     = dataEdge && !isWriteQ;
  assign rowEnd     = cfgQ[`CFG_NOWRAP_BIT] && (&addrQ[`ROW_LOG2-1:0]);
  assign sleepExit  = (stateQ == ST_SLEEP) && (exitCntQ == XW'(`SLEEP_EXIT_CYCLES - 1));

  // Wait timing bit set drops wait one clock ahead of the first data edge
  always_comb begin
    waitLvl = 1'b0;
    if (stateQ == ST_LAT) begin
      waitLvl = (latQ > (cfgQ[`CFG_WTIM_BIT] ? 5'h01 : 5'h00));
    end else if (stateQ == ST_ROWEND) begin
      waitLvl = 1'b1;
    end else if (stateQ == ST_DATA) begin
      waitLvl = isWriteQ && !fifoInReady;
    end
  end

  // ****************************************************************
  // Power-up and deep sleep sequencing
  // ****************************************************************
  // Init count restarts on every sleep exit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      initCntQ  <= '0;
      initDoneQ <= 1'b0;
    end else if (stateQ == ST_SLEEP) begin
      initCntQ  <= '0;
      initDoneQ <= 1'b0;
    end else if (!initDoneQ) begin
      initCntQ  <= initCntQ + IW'(1);
      initDoneQ <= (initCntQ == IW'(INIT_CYCLES - 1));
    end
  end

  // Select-low time only counts toward exit once the least sleep time has passed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sleepCntQ <= '0;
      exitCntQ  <= '0;
    end else if (stateQ != ST_SLEEP) begin
      sleepCntQ <= '0;
      exitCntQ  <= '0;
    end else begin
      if (sleepCntQ != SW'(SLEEP_MIN_CYCLES)) begin
        sleepCntQ <= sleepCntQ + SW'(1);
      end
      if (sSelN || (sleepCntQ != SW'(SLEEP_MIN_CYCLES))) begin
        exitCntQ <= '0;
      end else begin
        exitCntQ <= exitCntQ + XW'(1);
      end
    end
  end

  // ****************************************************************
  // Internal refresh scheduling
  // ****************************************************************
  // Refresh slips into any select-high cycle; the due flag's set wins over its clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      refCntQ     <= '0;
      refreshDueQ <= 1'b0;
    end else begin
      if (sSelN || collide) begin
        refreshDueQ <= 1'b0;
      end
      if (refCntQ == RW'(REFRESH_CYCLES - 1)) begin
        refCntQ     <= '0;
        refreshDueQ <= 1'b1;
      end else begin
        refCntQ <= refCntQ + RW'(1);
      end
    end
  end

  // ****************************************************************
  // Burst engine
  // ****************************************************************
  // A fresh address-valid edge overrides whatever burst is running
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateQ <= ST_INIT;
    end else begin
      case (stateQ)
        ST_INIT: begin
          if (initDoneQ) begin
            stateQ <= ST_IDLE;
          end
        end
        ST_SLEEP: begin
          if (sleepExit) begin
            stateQ <= ST_INIT;
          end
        end
        default: begin
          if (sSelN) begin
            stateQ <= sleepReqQ ? ST_SLEEP : ST_IDLE;
          end else if (burstStart) begin
            stateQ <= (latStart == 5'h00) ? ST_DATA : ST_LAT;
          end else if (clkRise && (stateQ == ST_LAT) && (latQ <= 5'h01)) begin
            stateQ <= ST_DATA;
          end else if ((wrEdge || rdEdge) && rowEnd) begin
            stateQ <= ST_ROWEND;
          end
        end
      endcase
    end
  end

  // Latency countdown, address and direction of the running burst
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      latQ     <= '0;
      addrQ    <= '0;
      isWriteQ <= 1'b0;
    end else if (burstStart) begin
      latQ     <= latStart;
      addrQ    <= sAddr;
      isWriteQ <= !sWeN;
    end else begin
      if (clkRise && (stateQ == ST_LAT) && (latQ != 5'h00)) begin
        latQ <= latQ - 5'h01;
      end
      if (wrEdge || rdEdge) begin
        addrQ <= addrQ + AW'(1);
      end
    end
  end

  // ****************************************************************
  // Array and write buffer
  // ****************************************************************
  logic [15:0]   mem [2**AW];
  logic [15:0]   rdWordQ;
  logic [AW-1:0] popAddr;
  logic          popUbN, popLbN;
  logic [15:0]   popData;
  logic          popFire;

  // Reads own the array port on their edge, so the buffer drain stalls there
  assign popFire = fifoOutValid && !rdEdge;
  assign {popUbN, popLbN, popData, popAddr} = fifoOutData;

  psram_word_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inValid  (wrEdge),
    .inReady  (fifoInReady),
    .inData   ({sUbN, sLbN, sDq, addrQ}),
    .outValid (fifoOutValid),
    .outReady (!rdEdge),
    .outData  (fifoOutData)
  );

  // Byte selects mask the drained write per lane
  always_ff @(posedge ref_clk) begin
    if (popFire && !popLbN) begin
      mem[popAddr][7:0] <= popData[7:0];
    end
    if (popFire && !popUbN) begin
      mem[popAddr][15:8] <= popData[15:8];
    end
    if (rdEdge) begin
      rdWordQ <= mem[addrQ];
    end
  end

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  // Word only moves on a read edge, so a stopped clock holds it on the bus
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dqOe    <= 1'b0;
      waitOut <= 1'b0;
      waitOe  <= 1'b0;
    end else begin
      dqOe    <= !sSelN && !sOeN && !isWriteQ
                 && ((stateQ == ST_DATA) || (stateQ == ST_ROWEND));
      waitOut <= cfgQ[`CFG_WPOL_BIT] ? waitLvl : !waitLvl;
      waitOe  <= !sSelN && initDoneQ && (stateQ != ST_SLEEP) && (stateQ != ST_INIT);
    end
  end
  assign dqOut = rdWordQ;

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  logic        wrAccQ, bvalidQ, rdAccQ, rvalidQ;
  logic [1:0]  brespQ, rrespQ;
  logic [31:0] rdataQ, rdMux;
  logic        rdHit;

  // Write address and data are taken together; one write in flight
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrAccQ    <= 1'b0;
      bvalidQ   <= 1'b0;
      brespQ    <= `RESP_OKAY;
      cfgQ      <= `CFG_RESET;
      sleepReqQ <= 1'b0;
    end else begin
      wrAccQ <= !wrAccQ && !bvalidQ && s_axi_awvalid && s_axi_wvalid;
      if (bvalidQ && s_axi_bready) begin
        bvalidQ <= 1'b0;
      end
      if ((stateQ != ST_SLEEP) && sSelN && sleepReqQ && (stateQ != ST_INIT)) begin
        sleepReqQ <= 1'b0;
      end
      if (wrAccQ) begin
        bvalidQ <= 1'b1;
        brespQ  <= `RESP_OKAY;
        if (s_axi_awaddr == `OFF_CONFIG) begin
          for (int b = 0; b < 2; b++) begin
            if (s_axi_wstrb[b]) begin
              cfgQ[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
            end
          end
        end else if (s_axi_awaddr == `OFF_CONTROL) begin
          if (s_axi_wstrb[0]) begin
            sleepReqQ <= s_axi_wdata[0];
          end
        end else if (s_axi_awaddr != `OFF_STATUS) begin
          brespQ <= `RESP_SLVERR;
        end
      end
    end
  end

  // Read decode
  always_comb begin
    rdHit = 1'b1;
    rdMux = 32'h0000_0000;
    if (s_axi_araddr == `OFF_CONFIG) begin
      rdMux = {16'h0000, cfgQ};
    end else if (s_axi_araddr == `OFF_STATUS) begin
      rdMux = {18'h0_0000, stateQ, 3'h0, isWriteQ, refreshDueQ, !fifoInReady, stateQ == ST_SLEEP, initDoneQ};
    end else if (s_axi_araddr == `OFF_CONTROL) begin
      rdMux = {31'h0000_0000, sleepReqQ};
    end else begin
      rdHit = 1'b0;
    end
  end

  // One read in flight; data held until rready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdAccQ  <= 1'b0;
      rvalidQ <= 1'b0;
      rdataQ  <= 32'h0000_0000;
      rrespQ  <= `RESP_OKAY;
    end else begin
      rdAccQ <= !rdAccQ && !rvalidQ && s_axi_arvalid;
      if (rvalidQ && s_axi_rready) begin
        rvalidQ <= 1'b0;
      end
      if (rdAccQ) begin
        rvalidQ <= 1'b1;
        rdataQ  <= rdMux;
        rrespQ  <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = wrAccQ;
  assign s_axi_wready  = wrAccQ;
  assign s_axi_bvalid  = bvalidQ;
  assign s_axi_bresp   = brespQ;
  assign s_axi_arready = rdAccQ;
  assign s_axi_rvalid  = rvalidQ;
  assign s_axi_rdata   = rdataQ;
  assign s_axi_rresp   = rrespQ;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seq_busy;
    (stateQ == ST_LAT) || (stateQ == ST_DATA);
  endsequence

  sequence seq_suspended;
    (stateQ == ST_DATA) && !isWriteQ && !sSelN && !sOeN && !clkRise;
  endsequence

  property p_init_gate;
    !initDoneQ |-> !((stateQ == ST_LAT) || (stateQ == ST_DATA));
  endproperty
  a_init_gate: assert property (p_init_gate) else $error("burst active before init done");

  property p_read_latency;
    burstStart && sWeN && !collide |=> latQ == 5'($past(lc)) + 5'h01;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read latency not code plus one");

  property p_collision_wait;
    collide |=> (latQ >= 5'($past(lc))) && (latQ <= 5'($past(lc)) * 5'h02);
  endproperty
  a_collision_wait: assert property (p_collision_wait) else $error("refresh hit wait out of range");

  property p_write_wait;
    burstStart && !sWeN |=> latQ == 5'($past(lc)) && isWriteQ;
  endproperty
  a_write_wait: assert property (p_write_wait) else $error("write wait not latency code");

  property p_lat_wait_pin;
    (stateQ == ST_LAT) && (latQ > 5'h01) |=> waitOut == cfgQ[`CFG_WPOL_BIT];
  endproperty
  a_lat_wait_pin: assert property (p_lat_wait_pin) else $error("wait not shown during latency");

  property p_suspend_hold;
    seq_suspended |=> dqOe && $stable(dqOut);
  endproperty
  a_suspend_hold: assert property (p_suspend_hold) else $error("suspended read word not held");

  property p_interrupt;
    seq_busy ##0 burstStart |=> (addrQ == $past(sAddr)) && (isWriteQ == !$past(sWeN));
  endproperty
  a_interrupt: assert property (p_interrupt) else $error("interrupting burst not taken");

endmodule : psram_burst_refresh_interface
`default_nettype wire

/* testbench/ctrl_model.sv */
// Burst controller model driving the memory link pins
`timescale 1ns/1ns
`default_nettype none
module ctrl_model (
  output logic             memClk,
  output logic             selectN,
  output logic             addr_valid_n,
  output logic             writeN,
  output logic             outEnN,
  output logic             low_byte_sel_n,
  output logic             high_byte_sel_n,
  output logic [7:0]       memAddr,
  output logic [15:0]      dqIn,
  input  wire logic [15:0] dqOut,
  input  wire logic        waitOut
);
  int          waits;
  int          done;
  logic [15:0] got [8];
  // ****
  // Idle link: clock parked low
  // ****
  initial begin
    {memClk, memAddr, dqIn} = '0;
    {selectN, addr_valid_n, writeN, outEnN, low_byte_sel_n, high_byte_sel_n} = '1;
  end
  // One burst; a read word is taken one clock after its data edge; pins move non-blocking
  task automatic burst(input logic wr, input logic [7:0] a, input int n, input logic [15:0] base, input logic keep);
    logic pend;
    pend = 1'b0;
    waits = 0;
    done = 0;
    selectN <= 1'b0;
    addr_valid_n <= 1'b0;
    writeN <= !wr;
    outEnN <= wr;
    memAddr <= a;
    {low_byte_sel_n, high_byte_sel_n} <= {2{!wr}};
    #40 memClk <= 1'b1;
    #80 memClk <= 1'b0;
    addr_valid_n <= 1'b1;
    while (done < n && waits < 40) begin
      #79;
      if (pend) begin
        got[done] = dqOut;
        done++;
        pend = 1'b0;
      end
      if (done == n) break;
      if (waitOut && done > 0) break;
      if (waitOut) waits++;
      else if (wr) begin
        dqIn <= base + 16'(done);
        done++;
      end else pend = 1'b1;
      // Clock moves only inside a frame, so a kept select is a suspend
      #1 memClk <= 1'b1;
      #80 memClk <= 1'b0;
    end
    writeN <= 1'b1;
    {low_byte_sel_n, high_byte_sel_n} <= 2'b11;
    dqIn <= ~dqIn;
    if (!keep) begin
      selectN <= 1'b1;
      outEnN <= 1'b1;
      #160;
    end
  endtask : burst
  // Rest past the sleep minimum, then a long select pulse
  task automatic wake;
    #600 selectN <= 1'b0;
    #10100 selectN <= 1'b1;
  endtask : wake
endmodule : ctrl_model
`default_nettype wire

/* testbench/psram_burst_refresh_interface_tb.sv */
// Self-checking bench for the burst memory block
`timescale 1ns/1ns
`default_nettype none
`include "psram_map.svh"
module psram_burst_refresh_interface_tb;
  import psram_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, m, e; logic [1:0] r;} row_t;
  logic        ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, memClk, selectN;
  logic        addr_valid_n, writeN, outEnN, low_byte_sel_n, high_byte_sel_n, dqOe, waitOut, waitOe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, memAddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] dqIn, dqOut;
  int          errTotal, testsRun;
  // Register cases: status mask, unmapped place, config reset and update
  row_t rows [6] = '{
    '{1'b0, `OFF_STATUS, 32'h0, 32'h0000_3F03, 32'h0000_0201, `RESP_OKAY},
    '{1'b1, 8'h0C, 32'h1234_5678, 32'h0, 32'h0, `RESP_SLVERR},
    '{1'b0, 8'h0C, 32'h0, 32'hFFFF_FFFF, 32'h0, `RESP_SLVERR},
    '{1'b0, `OFF_CONFIG, 32'h0, 32'hFFFF_FFFF, 32'h0000_9D1F, `RESP_OKAY},
    '{1'b1, `OFF_CONFIG, 32'h0000_1C1F, 32'h0, 32'h0, `RESP_OKAY},
    '{1'b0, `OFF_CONFIG, 32'h0, 32'hFFFF_FFFF, 32'h0000_1C1F, `RESP_OKAY}};
  psram_burst_refresh_interface #(.AW(8), .INIT_CYCLES(20), .SLEEP_MIN_CYCLES(20), .REFRESH_CYCLES(50))
    u_psram_burst_refresh_interface (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .memClk, .selectN, .addr_valid_n, .writeN, .outEnN, .low_byte_sel_n, .high_byte_sel_n, .memAddr, .dqIn,
    .dqOut, .dqOe, .waitOut, .waitOe);
  ctrl_model u_ctrl_model (.memClk, .selectN, .addr_valid_n, .writeN, .outEnN, .low_byte_sel_n,
    .high_byte_sel_n, .memAddr, .dqIn, .dqOut, .waitOut);
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ****
  // Bus tasks and comparison
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask : check
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
    do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b001;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge ref_clk);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    {s_axi_arvalid, s_axi_rready} <= 2'b01;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // Whole run needs about 23 us; hang cut well beyond that
  initial begin
    #200_000;
    errTotal++;
    summarize;
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd} = '0;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    axr(`OFF_STATUS);
    check(rd & 32'h0000_3F03, 32'h0000_0100);
    repeat (30) @(posedge ref_clk);
    foreach (rows[i]) begin
      if (rows[i].w) axw(rows[i].a, rows[i].d);
      else axr(rows[i].a);
      check(rd & rows[i].m, rows[i].e);
      check(32'(rsp), 32'(rows[i].r));
    end
    // Synchronous variable latency, latency code 3, wait active high
    u_ctrl_model.burst(1'b1, 8'h10, 4, 16'hA500, 1'b0);
    check(u_ctrl_model.waits, 3);
    u_ctrl_model.burst(1'b0, 8'h10, 4, 16'h0, 1'b0);
    check(32'(u_ctrl_model.waits >= 3 && u_ctrl_model.waits <= 6), 1);
    for (int i = 0; i < 4; i++) check(u_ctrl_model.got[i], 16'hA500 + i);
    // Suspended read keeps its word, then a read interrupts it
    u_ctrl_model.burst(1'b0, 8'h10, 2, 16'h0, 1'b1);
    repeat (20) @(posedge ref_clk);
    check({dqOe, waitOe, waitOut, dqOut}, {3'b110, 16'hA501});
    // Select stayed low past a refresh period, so this interrupting read hits the refresh
    u_ctrl_model.burst(1'b0, 8'h11, 1, 16'h0, 1'b1);
    check(u_ctrl_model.waits, 6);
    check(u_ctrl_model.got[0], 16'hA501);
    u_ctrl_model.burst(1'b1, 8'h20, 1, 16'h5A00, 1'b0);
    check(u_ctrl_model.waits, 3);
    u_ctrl_model.burst(1'b0, 8'h20, 1, 16'h0, 1'b0);
    check(u_ctrl_model.got[0], 16'h5A00);
    // Last word of a row with wrap off
    u_ctrl_model.burst(1'b1, 8'h7F, 2, 16'hC300, 1'b0);
    check(u_ctrl_model.done, 1);
    u_ctrl_model.burst(1'b0, 8'h7F, 1, 16'h0, 1'b0);
    check(u_ctrl_model.got[0], 16'hC300);
    // Deep sleep entry and exit re-runs initialization
    axw(`OFF_CONTROL, 32'h0000_0001);
    axr(`OFF_STATUS);
    check(rd & 32'h0000_3F02, 32'h0000_2002);
    axr(`OFF_CONTROL);
    check(rd, 32'h0);
    u_ctrl_model.wake;
    axr(`OFF_STATUS);
    check(rd & 32'h0000_3F03, 32'h0000_0100);
    summarize;
  end
endmodule : psram_burst_refresh_interface_tb
`default_nettype wire
